// ---- rtl/pulse_measure_timer.sv ----
// Design decision made here: the APB register port.
`timescale 1ns/1ns
// Operation
// - width mode: polarity 0 measures low width, 1 measures high width
// - filter field: off, or filtering sampled at f1, f8 or f32
// - filtered input changes only after three equal consecutive samples
// - period mode: edge captures read-out buffer, next tick reloads counter
// - period mode: polarity 0 rising to rising, 1 falling to falling
// - start 1 begins counting; start 0 or forced stop ends it
// - period mode event pulse on underflow, reload and ending edge
// - counter write when stopped loads reload register and counter
// - period mode counter read gives buffer, held until read
// - reload on third count tick after edge, flag two edges later
// - flags set at second clock edge after underflow, both if coincident
// - writing 0 clears edge and underflow flags, 1 leaves them
// - timer is stopped after reset; load counter before starting
// - status rises within one count tick of start; counting follows
// - status falls within one count tick of stop; counting halts
// - width mode counts only at selected level; event at underflow, edge
module pulse_measure_timer #(
  parameter int COUNT_W = 16,
  parameter int OSC_DIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_pin,
  output logic timer_event,
  output logic count_status_bit
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  localparam int OW = $clog2(OSC_DIV + 1);
  localparam logic [OW-1:0] OSC_END = OW'(OSC_DIV - 1);

  logic [7:0] pin_io_control;
  logic [7:0] timer_mode_reg;
  logic count_start_bit;
  logic edge_received_flag;
  logic underflow_flag;
  logic [COUNT_W-1:0] counter;
  logic [COUNT_W-1:0] reload;
  logic [COUNT_W-1:0] readout_buf;
  logic buf_free;
  logic [4:0] div_cnt;
  logic [OW-1:0] osc_cnt;
  logic cs_tick;
  logic filt_tick;
  logic pin_synced;
  logic pin_level;
  logic pin_level_d;
  logic rise;
  logic fall;
  logic active_edge;
  logic edge_arm;
  logic [1:0] edge_pipe;
  logic [1:0] unf_pipe;
  logic ev_edge;
  logic ev_unf;
  logic counting;
  logic at_level;
  logic period_mode;
  logic polarity_select;
  logic [1:0] filter_sel;
  logic [1:0] src_sel;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic [9:0] word;
  logic hit_ctl;
  logic hit_ioc;
  logic hit_mode;
  logic hit_cnt;
  logic mapped;
  logic [31:0] next_prdata;
  pmt_pkg::cap_state_t cap_state;

  generate
    if (COUNT_W < 2 || COUNT_W > 32 || OSC_DIV < 1) begin : g_bad
      $error("pulse_measure_timer parameters out of range");
    end
  endgenerate

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign word = paddr[pmt_pkg::ADDR_W-1:2];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite && ce;
  assign rd = access && !pwrite && ce;
  assign hit_ctl = word == {2'b00, pmt_pkg::IDX_TIMER_CONTROL};
  assign hit_ioc = word == {2'b00, pmt_pkg::IDX_PIN_IO_CONTROL};
  assign hit_mode = word == {2'b00, pmt_pkg::IDX_TIMER_MODE};
  assign hit_cnt = word == {2'b00, pmt_pkg::IDX_COUNTER};
  assign mapped = hit_ctl || hit_ioc || hit_mode || hit_cnt;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // field aliases
  assign polarity_select = pin_io_control[pmt_pkg::IOC_POL];
  assign filter_sel = pin_io_control[pmt_pkg::IOC_FILT_LO +: 2];
  assign period_mode = timer_mode_reg[pmt_pkg::MODE_SEL];
  assign src_sel = timer_mode_reg[pmt_pkg::MODE_SRC_LO +: 2];

  // ------------------------------------------------------------
  // prescaler for count source and filter sampling
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      osc_cnt <= '0;
    end else if (ce) begin
      div_cnt <= div_cnt + 1'b1;
      if (osc_cnt == OSC_END) begin
        osc_cnt <= '0;
      end else begin
        osc_cnt <= osc_cnt + 1'b1;
      end
    end
  end

  // count source tick select
  always_comb begin
    case (src_sel)
      pmt_pkg::SRC_F1: cs_tick = 1'b1;
      pmt_pkg::SRC_F2: cs_tick =
        (div_cnt & pmt_pkg::MASK2) == pmt_pkg::DIV2_END;
      pmt_pkg::SRC_F8: cs_tick =
        (div_cnt & pmt_pkg::MASK8) == pmt_pkg::DIV8_END;
      pmt_pkg::SRC_OSC: cs_tick = osc_cnt == OSC_END;
      default: cs_tick = 1'b0;
    endcase
  end

  // filter sampling strobe
  always_comb begin
    case (filter_sel)
      pmt_pkg::FILT_F1: filt_tick = 1'b1;
      pmt_pkg::FILT_F8: filt_tick =
        (div_cnt & pmt_pkg::MASK8) == pmt_pkg::DIV8_END;
      pmt_pkg::FILT_F32: filt_tick = div_cnt == pmt_pkg::DIV32_END;
      default: filt_tick = 1'b1;
    endcase
  end

  // ------------------------------------------------------------
  // pulse pin conditioning
  // ------------------------------------------------------------
  pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(pulse_pin),
    .dout(pin_synced)
  );

  pin_filter #(
    .SAMPLES(pmt_pkg::FILTER_SAMPLES)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sample_en(filt_tick),
    .bypass(filter_sel == pmt_pkg::FILT_OFF),
    .din(pin_synced),
    .dout(pin_level)
  );

  // edge detect on the filtered level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_d <= 1'b0;
    end else if (ce) begin
      pin_level_d <= pin_level;
    end
  end

  assign rise = pin_level && !pin_level_d;
  assign fall = !pin_level && pin_level_d;
  assign active_edge = polarity_select ? fall : rise;
  assign at_level = pin_level == polarity_select;
  assign counting = count_status_bit && cs_tick;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_io_control <= pmt_pkg::IOC_RESET;
      timer_mode_reg <= pmt_pkg::MODE_RESET;
    end else if (wr) begin
      if (hit_ioc) begin
        pin_io_control <= pwdata[7:0] & pmt_pkg::IOC_WMASK;
      end
      if (hit_mode) begin
        timer_mode_reg <= pwdata[7:0];
      end
    end
  end

  // start request, stopped after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_start_bit <= 1'b0;
    end else if (wr && hit_ctl) begin
      if (pwdata[pmt_pkg::CTL_FSTOP]) begin
        count_start_bit <= 1'b0;
      end else begin
        count_start_bit <= pwdata[pmt_pkg::CTL_START];
      end
    end
  end

  // status follows start at the next count tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_status_bit <= 1'b0;
    end else if (ce) begin
      if (wr && hit_ctl && pwdata[pmt_pkg::CTL_FSTOP]) begin
        count_status_bit <= 1'b0;
      end else if (cs_tick) begin
        count_status_bit <= count_start_bit;
      end
    end
  end

  // ------------------------------------------------------------
  // period capture sequence
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_arm <= 1'b0;
    end else if (ce) begin
      if (!count_status_bit || !period_mode) begin
        edge_arm <= 1'b0;
      end else if (active_edge) begin
        edge_arm <= 1'b1;
      end else if (counting && cap_state == pmt_pkg::CAP_IDLE) begin
        edge_arm <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_state <= pmt_pkg::CAP_IDLE;
    end else if (ce) begin
      if (!count_status_bit || !period_mode) begin
        cap_state <= pmt_pkg::CAP_IDLE;
      end else if (counting) begin
        case (cap_state)
          pmt_pkg::CAP_IDLE: begin
            if (edge_arm) begin
              cap_state <= pmt_pkg::CAP_TAKE;
            end
          end
          pmt_pkg::CAP_TAKE: cap_state <= pmt_pkg::CAP_LOAD;
          pmt_pkg::CAP_LOAD: cap_state <= pmt_pkg::CAP_IDLE;
          default: cap_state <= pmt_pkg::CAP_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // counter and reload register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= '0;
      reload <= '0;
    end else if (ce) begin
      if (wr && hit_cnt) begin
        counter <= pwdata[COUNT_W-1:0];
        reload <= pwdata[COUNT_W-1:0];
      end else if (counting) begin
        if (period_mode && cap_state == pmt_pkg::CAP_LOAD) begin
          counter <= reload;
        end else if (period_mode || at_level) begin
          if (counter == '0) begin
            counter <= reload;
          end else begin
            counter <= counter - 1'b1;
          end
        end
      end
    end
  end

  // read-out buffer, kept until software reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readout_buf <= '0;
      buf_free <= 1'b1;
    end else if (ce) begin
      if (counting && period_mode && cap_state == pmt_pkg::CAP_TAKE &&
          buf_free) begin
        readout_buf <= counter;
        buf_free <= 1'b0;
      end else if (rd && hit_cnt && period_mode) begin
        buf_free <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // events
  // ------------------------------------------------------------
  always_comb begin
    ev_unf = 1'b0;
    ev_edge = 1'b0;
    if (counting && period_mode) begin
      ev_unf = counter == '0 || cap_state == pmt_pkg::CAP_LOAD;
      ev_edge = cap_state == pmt_pkg::CAP_LOAD;
    end else if (counting && at_level) begin
      ev_unf = counter == '0;
    end
    if (count_status_bit && !period_mode && ce) begin
      ev_edge = polarity_select ? fall : rise;
    end
  end

  // event pulse, delayed flag pipelines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_event <= 1'b0;
      edge_pipe <= '0;
      unf_pipe <= '0;
    end else if (ce) begin
      timer_event <= ev_unf || ev_edge;
      edge_pipe <= {edge_pipe[0], ev_edge};
      unf_pipe <= {unf_pipe[0], ev_unf};
    end
  end

  // flags: write 0 clears, hardware set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_received_flag <= 1'b0;
      underflow_flag <= 1'b0;
    end else if (ce) begin
      if (edge_pipe[1]) begin
        edge_received_flag <= 1'b1;
      end else if (wr && hit_ctl && !pwdata[pmt_pkg::CTL_EDGF]) begin
        edge_received_flag <= 1'b0;
      end
      if (unf_pipe[1]) begin
        underflow_flag <= 1'b1;
      end else if (wr && hit_ctl && !pwdata[pmt_pkg::CTL_UNDF]) begin
        underflow_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // read data, latched in the setup cycle
  // ------------------------------------------------------------
  always_comb begin
    next_prdata = '0;
    if (hit_ctl) begin
      next_prdata[pmt_pkg::CTL_START] = count_start_bit;
      next_prdata[pmt_pkg::CTL_STATUS] = count_status_bit;
      next_prdata[pmt_pkg::CTL_EDGF] = edge_received_flag;
      next_prdata[pmt_pkg::CTL_UNDF] = underflow_flag;
    end else if (hit_ioc) begin
      next_prdata[7:0] = pin_io_control;
    end else if (hit_mode) begin
      next_prdata[7:0] = timer_mode_reg;
    end else if (hit_cnt) begin
      next_prdata[COUNT_W-1:0] = period_mode ? readout_buf : counter;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (ce && setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule

// ---- rtl/pmt_pkg.sv ----
package pmt_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h80;
  localparam logic [7:0] IDX_PIN_IO_CONTROL = 8'h81;
  localparam logic [7:0] IDX_TIMER_MODE = 8'h82;
  localparam logic [7:0] IDX_COUNTER = 8'h84;
  localparam int ADDR_W = 12;

  // ------------------------------------------------------------
  // timer_control fields
  // ------------------------------------------------------------
  localparam int CTL_START = 0;
  localparam int CTL_STATUS = 1;
  localparam int CTL_FSTOP = 2;
  localparam int CTL_EDGF = 4;
  localparam int CTL_UNDF = 5;

  // ------------------------------------------------------------
  // pin_io_control fields
  // ------------------------------------------------------------
  localparam int IOC_POL = 0;
  localparam int IOC_OUTCTL = 1;
  localparam int IOC_RSVD = 2;
  localparam int IOC_UNUSED = 3;
  localparam int IOC_FILT_LO = 4;
  localparam int IOC_GATE_LO = 6;
  localparam logic [7:0] IOC_RESET = 8'h00;
  localparam logic [7:0] IOC_WMASK = 8'hf7;

  // ------------------------------------------------------------
  // timer_mode_reg fields and codes, pin_io_control filter codes
  // ------------------------------------------------------------
  localparam int MODE_SEL = 0;
  localparam int MODE_SRC_LO = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F2 = 2'h1;
  localparam logic [1:0] SRC_F8 = 2'h2;
  localparam logic [1:0] SRC_OSC = 2'h3;
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_F1 = 2'h1;
  localparam logic [1:0] FILT_F8 = 2'h2;
  localparam logic [1:0] FILT_F32 = 2'h3;

  // ------------------------------------------------------------
  // prescaler terminal counts
  // ------------------------------------------------------------
  localparam logic [4:0] DIV2_END = 5'h01;
  localparam logic [4:0] DIV8_END = 5'h07;
  localparam logic [4:0] DIV32_END = 5'h1f;
  localparam logic [4:0] MASK2 = 5'h01;
  localparam logic [4:0] MASK8 = 5'h07;
  localparam int FILTER_SAMPLES = 3;

  // period capture sequence
  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_TAKE = 3'b010,
    CAP_LOAD = 3'b100
  } cap_state_t;

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic din,
  output logic dout
);

  logic stage1;

  // ------------------------------------------------------------
  // two flip-flop synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

// ---- rtl/pin_filter.sv ----
`timescale 1ns/1ns
module pin_filter #(
  parameter int SAMPLES = pmt_pkg::FILTER_SAMPLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic sample_en,
  input wire logic bypass,
  input wire logic din,
  output logic dout
);

  localparam int CW = $clog2(SAMPLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);

  logic [CW-1:0] same_cnt;
  logic last_sample;

  generate
    if (SAMPLES < 2) begin : g_bad
      $error("pin_filter needs at least two samples");
    end
  endgenerate

  // ------------------------------------------------------------
  // run length of equal samples, level taken when it is reached
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      same_cnt <= '0;
      last_sample <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      if (bypass) begin
        dout <= din;
        last_sample <= din;
        same_cnt <= '0;
      end else if (sample_en) begin
        last_sample <= din;
        if (din != last_sample) begin
          same_cnt <= '0;
        end else if (same_cnt < LAST) begin
          same_cnt <= same_cnt + 1'b1;
        end
        if (din == last_sample && same_cnt >= LAST - 1'b1) begin
          dout <= din;
        end
      end
    end
  end

endmodule

// ---- testbench/pmt_props.sv ----
`timescale 1ns/1ns
module pmt_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic timer_event,
  input wire logic count_status_bit
);
  logic acc;
  logic [7:0] idx;
  logic wr_ctl;
  logic go;
  logic [7:0] since_go;
  // ----------------------------------------
  // access decode
  // ----------------------------------------
  assign acc = psel && penable && ce && paddr[11:10] == 2'b00;
  assign idx = paddr[9:2];
  assign wr_ctl = acc && pwrite && idx == pmt_pkg::IDX_TIMER_CONTROL;
  assign go = wr_ctl && pwdata[0] && !pwdata[2];
  // cycles since the last start request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_go <= 8'hff;
    end else if (go) begin
      since_go <= 8'h00;
    end else if (since_go != 8'hff) begin
      since_go <= since_go + 8'h01;
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_reset_stopped: assert property (
    $rose(presetn) |-> !count_status_bit && !timer_event)
    else $error("timer active right after reset");
  a_start_status: assert property (
    go && !count_status_bit |-> ##[1:20] count_status_bit)
    else $error("status did not follow start");
  a_rise_cause: assert property (
    $rose(count_status_bit) |-> since_go <= 8'h14)
    else $error("status rose without start");
  a_stop_status: assert property (
    wr_ctl && !pwdata[0] && count_status_bit |-> ##[1:20] !count_status_bit)
    else $error("status did not follow stop");
  a_fstop_status: assert property (
    wr_ctl && pwdata[2] |=> ##[0:1] !count_status_bit)
    else $error("forced stop ignored");
  a_ioc_bit3: assert property (
    acc && !pwrite && idx == pmt_pkg::IDX_PIN_IO_CONTROL
      |-> prdata[3] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("unassigned io control bit read nonzero");
  a_fstop_reads: assert property (
    acc && !pwrite && idx == pmt_pkg::IDX_TIMER_CONTROL |-> !prdata[2])
    else $error("forced stop bit read nonzero");
  a_count_width: assert property (
    acc && !pwrite && idx == pmt_pkg::IDX_COUNTER |-> prdata[31:16] == 16'h0)
    else $error("counter read wider than 16 bits");
endmodule

bind pulse_measure_timer pmt_props pmt_props_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .timer_event(timer_event),
  .count_status_bit(count_status_bit)
);

// ---- testbench/pulse_source.sv ----
`timescale 1ns/1ns
module pulse_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic idle_level,
  input wire logic [15:0] act,
  input wire logic [15:0] per,
  output logic pulse_pin
);
  logic [15:0] phase;
  // phase within the pulse period, parked while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 16'h0000;
    end else if (!run || phase == per - 16'h0001) begin
      phase <= 16'h0000;
    end else begin
      phase <= phase + 16'h0001;
    end
  end
  // active level for the first act cycles of each period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_pin <= 1'b0;
    end else begin
      pulse_pin <= (run && phase < act) ? !idle_level : idle_level;
    end
  end
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] CTL = pmt_pkg::IDX_TIMER_CONTROL;
  localparam logic [7:0] IOC = pmt_pkg::IDX_PIN_IO_CONTROL;
  localparam logic [7:0] MOD = pmt_pkg::IDX_TIMER_MODE;
  localparam logic [7:0] CNT = pmt_pkg::IDX_COUNTER;
  logic pclk, presetn, ce, psel, penable, pwrite, run, idle_level;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, pulse_pin, timer_event, count_status_bit;
  logic [15:0] act, per;
  int num_errors = 0;
  int cmp_count = 0;
  int ev_cnt = 0;
  // ----------------------------------------
  // clock, design and pulse source
  // ----------------------------------------
  always #50 pclk = ~pclk;
  // event pulse counter
  always @(posedge pclk) begin
    if (timer_event === 1'b1) ev_cnt <= ev_cnt + 1;
  end
  pulse_measure_timer pulse_measure_timer_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_pin(pulse_pin), .timer_event(timer_event),
    .count_status_bit(count_status_bit)
  );
  pulse_source pulse_source_i (
    .pclk(pclk), .presetn(presetn), .run(run), .idle_level(idle_level),
    .act(act), .per(per), .pulse_pin(pulse_pin)
  );
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] exp,
      input logic [31:0] mask);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(q & mask, exp);
  endtask
  task automatic wait_st(input logic v);
    int n;
    n = 0;
    // only the status pin is watched in the window
    while (count_status_bit !== v && n < 4) begin
      @(posedge pclk);
      n++;
    end
    cmp({31'h0, count_status_bit}, {31'h0, v});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reg_case;
    logic [31:0] q;
    logic e;
    chk(IOC, {24'h0, pmt_pkg::IOC_RESET}, 32'hff);
    chk(MOD, {24'h0, pmt_pkg::MODE_RESET}, 32'hff);
    chk(CTL, 32'h0, 32'h37);
    wr(IOC, 32'hff);
    chk(IOC, {24'h0, pmt_pkg::IOC_WMASK}, 32'hffffffff);
    wr(IOC, 32'h0);
    apb(1'b0, 8'h83, 32'h0, q, e);
    cmp({31'h0, e}, 32'h1);
    cmp(q, 32'h0);
  endtask
  // one pulse measured in width mode
  task automatic width_case(input logic pol, input logic [1:0] filt,
      input logic [15:0] w, input logic [15:0] load,
      input logic [15:0] exp_cnt, input logic [1:0] flg, input int exp_ev);
    int ev0;
    @(posedge pclk);
    idle_level <= !pol;
    act <= w;
    wr(IOC, {26'h0, filt, 3'h0, pol});
    wr(MOD, 32'h0);
    wr(CTL, 32'h0);
    wr(CNT, {16'h0, load});
    chk(CNT, {16'h0, load}, 32'hffffffff);
    wr(CTL, 32'h31);
    wait_st(1'b1);
    ev0 = ev_cnt;
    run <= 1'b1;
    repeat (w + 8) @(posedge pclk);
    run <= 1'b0;
    repeat (16) @(posedge pclk);
    wr(CTL, 32'h30);
    wait_st(1'b0);
    cmp(32'(ev_cnt - ev0), 32'(exp_ev));
    chk(CNT, {16'h0, exp_cnt}, 32'hffffffff);
    chk(CTL, {26'h0, flg, 4'h0}, 32'h37);
    wr(CTL, 32'h20);
    chk(CTL, {26'h0, flg & 2'b10, 4'h0}, 32'h30);
  endtask
  // steady pulse train measured in period mode
  task automatic period_case(input logic pol);
    logic [31:0] v1, v2;
    logic e;
    @(posedge pclk);
    idle_level <= pol;
    act <= 16'h000a;
    per <= 16'h0032;
    wr(IOC, {31'h0, pol});
    wr(MOD, 32'h1);
    wr(CTL, 32'h0);
    wr(CNT, 32'h1000);
    wr(CTL, 32'h31);
    wait_st(1'b1);
    run <= 1'b1;
    repeat (120) @(posedge pclk);
    wr(CTL, 32'h21);
    apb(1'b0, CNT, 32'h0, v1, e);
    repeat (150) @(posedge pclk);
    apb(1'b0, CNT, 32'h0, v1, e);
    repeat (150) @(posedge pclk);
    apb(1'b0, CNT, 32'h0, v2, e);
    cmp(v2, v1);
    cmp({24'h0, v1[15:8]}, 32'h0f);
    @(posedge pclk);
    run <= 1'b0;
    repeat (100) @(posedge pclk);
    chk(CTL, 32'h33, 32'h33);
    wr(CTL, 32'h21);
    chk(CTL, 32'h23, 32'h33);
    wr(CTL, 32'h35);
    wait_st(1'b0);
    wr(MOD, 32'h0);
    apb(1'b0, CNT, 32'h0, v1, e);
    repeat (20) @(posedge pclk);
    apb(1'b0, CNT, 32'h0, v2, e);
    cmp(v2, v1);
  endtask
  // clock enable low freezes the running count
  task automatic ce_case;
    logic [31:0] v1, v2;
    logic e;
    @(posedge pclk);
    idle_level <= 1'b0;
    wr(IOC, 32'h0);
    wr(CNT, 32'h1000);
    wr(CTL, 32'h31);
    wait_st(1'b1);
    apb(1'b0, CNT, 32'h0, v1, e);
    @(posedge pclk);
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, CNT, 32'h0, v2, e);
    cmp(v1 - v2, 32'h4);
    wr(CTL, 32'h34);
    wait_st(1'b0);
  endtask
  task automatic print_verdict;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    run = 1'b0;
    idle_level = 1'b0;
    act = 16'h0;
    per = 16'hffff;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    reg_case();
    width_case(1'b1, 2'h0, 16'h0014, 16'h0100, 16'h00ec, 2'b01, 1);
    width_case(1'b0, 2'h0, 16'h0014, 16'h0100, 16'h00ec, 2'b01, 1);
    width_case(1'b1, 2'h1, 16'h0014, 16'h0100, 16'h00ec, 2'b01, 1);
    width_case(1'b1, 2'h0, 16'h0014, 16'h0005, 16'h0003, 2'b11, 4);
    for (int f = 1; f < 4; f++) begin
      width_case(1'b1, 2'(f), 16'h0002, 16'h0100, 16'h0100, 2'b00, 0);
    end
    period_case(1'b0);
    period_case(1'b1);
    ce_case();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end
endmodule
